// File: shared/lamp_defs.vh
// constants for the lamp driver control logic
`ifndef LAMP_DEFS_VH
`define LAMP_DEFS_VH
// configuration register layout and reset value
`define CFG_RESET        8'h18
`define CFG_USED_MASK    8'h9b
`define CFG_RETRY_BIT    7
`define CFG_OL_BIT       4
`define CFG_INRUSH_BIT   3
`define CFG_SEL_HI       1
`define CFG_SEL_LO       0
// lamp control register: duty field and reset
`define CTL_RESET        8'h00
`define CTL_DUTY_MSB     6
`define CTL_USED_MASK    8'h7f
// pwm source select codes
`define SEL_NONE         2'h0
`define SEL_100HZ        2'h1
`define SEL_1KHZ         2'h2
`define SEL_EXTFREQ      2'h3
// clock and pwm timing
`define CLK_HZ           20000000
`define CLK_MHZ          24'h000014
`define PWM_STEPS        128
`define FREQ_LO_HZ       100
`define FREQ_HI_HZ       1000
`define STEP_LO_CYC      (`CLK_HZ / (`FREQ_LO_HZ * `PWM_STEPS))
`define STEP_HI_CYC      (`CLK_HZ / (`FREQ_HI_HZ * `PWM_STEPS))
// protection timing, times in microseconds, counts in clock cycles
`define OC_FILT_US       24'h000001
`define OC_FILT_CYC      (`OC_FILT_US * `CLK_MHZ)
`define INRUSH_US        24'h0007d0
`define INRUSH_CYC       (`INRUSH_US * `CLK_MHZ)
`define RETRY_ON_US      24'h000064
`define RETRY_ON_CYC     (`RETRY_ON_US * `CLK_MHZ)
`define RETRY_OFF_US     24'h000320
`define RETRY_OFF_CYC    (`RETRY_OFF_US * `CLK_MHZ)
`define OL_FILT_US       24'h00000a
`define OL_FILT_CYC      (`OL_FILT_US * `CLK_MHZ)
// common counter width
`define CNT_W            24
`endif

// File: src/lamp_driver_control.v
// lamp output control: on/off, pwm, overcurrent retry, inrush delay, open load
//
// Notes on behaviour
// [R1] lamp bit of on/off word switches output
// [R2] lamp control register sets pwm dimming
// [R3] retry bit cycles output short on, long off
// [R4] bit 4 enables open-load sink, default on
// [R5] bit 3 adds inrush delay before overcurrent
// [R6] internal duty from low seven control bits
// [R7] input pin switches output when no pwm source is selected
// [R8] bits 1:0 pick pwm source and frequency
// [R9] sink detects open filament, raises fault
// [R10] bits 6, 5, 2 unused, read zero
// [R11] protection times are cycle-count parameters
// [R12] reset gives config with inrush and sink on
`default_nettype none
`include "lamp_defs.vh"
module lamp_driver_control #(
    parameter [23:0] INRUSH_CYC    = `INRUSH_CYC,     // inrush tolerance
    parameter [23:0] RETRY_ON_CYC  = `RETRY_ON_CYC,   // retry on interval
    parameter [23:0] RETRY_OFF_CYC = `RETRY_OFF_CYC,  // retry off interval
    parameter [23:0] OC_FILT_CYC   = `OC_FILT_CYC,    // plain overcurrent filter
    parameter [23:0] OL_FILT_CYC   = `OL_FILT_CYC     // open-load filter
) (
    // clock and reset
    input  wire         clock_in,
    input  wire         rst_in,
    // register writes from the serial port decoder
    input  wire         cfg_wr_in,
    input  wire [7:0]   cfg_data_in,
    input  wire         ctl_wr_in,
    input  wire [7:0]   ctl_data_in,
    input  wire         onoff_wr_in,
    input  wire         lamp_on_in,
    input  wire         fault_clr_in,
    // register read-back
    output reg  [7:0]   cfg_rd_out,
    output reg  [7:0]   ctl_rd_out,
    output reg          lamp_bit_out,
    output reg          oc_fault_out,
    output reg          ol_fault_out,
    // pins and analog comparators, asynchronous
    input  wire         ext_pin_in,
    input  wire         oc_det_in,
    input  wire         ol_det_in,
    // power stage controls
    output reg          lamp_drive_out,
    output reg          open_load_sink_out
);
    // protection state codes
    localparam [1:0] ST_RUN   = 2'h0;   // normal drive
    localparam [1:0] ST_TRIP  = 2'h1;   // latched off, no retry
    localparam [1:0] ST_OFF   = 2'h2;   // retry long off interval
    localparam [1:0] ST_RETRY = 2'h3;   // retry short on interval

    // count reaches its limit (limit of zero treated as one)
    function reached;
        input [23:0] cnt;
        input [23:0] lim;
        begin
            reached = (cnt + 24'h000001 >= lim);
        end
    endfunction

    reg  [2:0]          sync1_q;        // first synchroniser stage
    reg  [2:0]          sync2_q;        // second synchroniser stage
    wire                ext_s;          // synchronised input pin
    wire                oc_s;           // synchronised overcurrent
    wire                ol_s;           // synchronised open-load comparator
    wire [2:0]          async_in;       // bundle of asynchronous inputs
    reg  [7:0]          cfg_q;          // configuration register
    reg  [7:0]          ctl_q;          // lamp control register
    reg                 lamp_q;         // lamp bit of on/off word
    wire                pwm_w;          // generated pwm waveform
    reg                 cmd;            // commanded output before protection
    reg  [1:0]          state_q;        // protection state
    reg  [1:0]          state_d;        // next protection state
    reg  [23:0]         tmr_q;          // retry interval timer
    reg  [23:0]         oc_cnt_q;       // overcurrent persistence count
    reg  [23:0]         ol_cnt_q;       // open-load persistence count
    wire [23:0]         oc_lim;         // persistence needed before tripping
    wire                oc_trip;        // overcurrent confirmed this cycle
    wire                ol_hit;         // open load confirmed this cycle
    wire                lamp_off_wr;    // host commands lamp off
    wire                drive_d;        // next output drive

    assign async_in = {ol_det_in, oc_det_in, ext_pin_in};
    assign ext_s    = sync2_q[0];
    assign oc_s     = sync2_q[1];
    assign ol_s     = sync2_q[2];

    // two-stage synchronisers for pin and comparator inputs
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1)
        begin : g_sync
            always @(posedge clock_in)
            begin
                if (rst_in)
                begin
                    sync1_q[gi] <= 1'b0;
                    sync2_q[gi] <= 1'b0;
                end
                else
                begin
                    sync1_q[gi] <= async_in[gi];
                    sync2_q[gi] <= sync1_q[gi];
                end
            end
        end
    endgenerate

    // host registers; unused config bits forced to zero
    always @(posedge clock_in)
    begin
        if (rst_in)
        begin
            cfg_q  <= `CFG_RESET;                       // [R12]
            ctl_q  <= `CTL_RESET;
            lamp_q <= 1'b0;
        end
        else
        begin
            if (cfg_wr_in)
                cfg_q <= cfg_data_in & `CFG_USED_MASK;  // [R10]
            if (ctl_wr_in)
                ctl_q <= ctl_data_in & `CTL_USED_MASK;  // [R2]
            if (onoff_wr_in)
                lamp_q <= lamp_on_in;                   // [R1]
        end
    end

    // pwm generator, duty from the low seven control bits
    lamp_pwm_timer u_pwm (
        .clock_in (clock_in),
        .rst_in   (rst_in),
        .sel_in   (cfg_q[`CFG_SEL_HI:`CFG_SEL_LO]),    // [R8]
        .ext_in   (ext_s),
        .duty_in  (ctl_q[`CTL_DUTY_MSB:0]),             // [R6]
        .pwm_out  (pwm_w)
    );

    // command selection by pwm source
    always @*
    begin
        cmd = 1'b0;
        case (cfg_q[`CFG_SEL_HI:`CFG_SEL_LO])          // [R8]
            `SEL_NONE:
                cmd = lamp_q | ext_s;                   // [R7]
            `SEL_100HZ, `SEL_1KHZ, `SEL_EXTFREQ:
                cmd = lamp_q & pwm_w;                   // [R1]
            default:
                cmd = 1'b0;
        endcase
    end

    // overcurrent must persist; longer with inrush delay set
    assign oc_lim  = cfg_q[`CFG_INRUSH_BIT] ? INRUSH_CYC : OC_FILT_CYC;  // [R5]
    assign oc_trip = oc_s & lamp_drive_out & reached(oc_cnt_q, oc_lim);
    assign lamp_off_wr = onoff_wr_in & ~lamp_on_in;

    // persistence counter, cleared whenever current is normal or output off
    always @(posedge clock_in)
    begin
        if (rst_in)
            oc_cnt_q <= 24'h000000;
        else if (~oc_s | ~lamp_drive_out | (state_q != ST_RUN) | oc_trip)
            oc_cnt_q <= 24'h000000;
        else
            oc_cnt_q <= oc_cnt_q + 24'h000001;                           // [R11]
    end

    // protection state machine
    always @*
    begin
        state_d = state_q;
        case (state_q)
            ST_RUN:
                if (oc_trip)
                    state_d = cfg_q[`CFG_RETRY_BIT] ? ST_OFF : ST_TRIP;  // [R3]
            ST_TRIP:
                if (lamp_off_wr)
                    state_d = ST_RUN;
                else if (cfg_q[`CFG_RETRY_BIT])
                    state_d = ST_OFF;
            ST_OFF:
                if (~cfg_q[`CFG_RETRY_BIT])
                    state_d = ST_TRIP;
                else if (reached(tmr_q, RETRY_OFF_CYC))
                    state_d = ST_RETRY;                                 // [R3]
            ST_RETRY:
                if (reached(tmr_q, RETRY_ON_CYC))
                    state_d = oc_s ? ST_OFF : ST_RUN;                   // [R3]
            default:
                state_d = ST_RUN;
        endcase
    end

    // state and interval timer, timer restarts on each state change
    always @(posedge clock_in)
    begin
        if (rst_in)
        begin
            state_q <= ST_RUN;
            tmr_q   <= 24'h000000;
        end
        else
        begin
            state_q <= state_d;
            if (state_d != state_q)
                tmr_q <= 24'h000000;
            else
                tmr_q <= tmr_q + 24'h000001;                            // [R11]
        end
    end

    // output drive, off in trip and retry-off states
    assign drive_d = ((state_d == ST_RUN) | (state_d == ST_RETRY)) & cmd;

    // open load: sink active with output low means no filament pull-up
    assign ol_hit = open_load_sink_out & ol_s & reached(ol_cnt_q, OL_FILT_CYC);

    // open-load persistence counter
    always @(posedge clock_in)
    begin
        if (rst_in)
            ol_cnt_q <= 24'h000000;
        else if (~open_load_sink_out | ~ol_s | ol_hit)
            ol_cnt_q <= 24'h000000;
        else
            ol_cnt_q <= ol_cnt_q + 24'h000001;
    end

    // power stage and sink; sink only while the output is off
    always @(posedge clock_in)
    begin
        if (rst_in)
        begin
            lamp_drive_out     <= 1'b0;
            open_load_sink_out <= 1'b0;
        end
        else
        begin
            lamp_drive_out     <= drive_d;                               // [R1]
            open_load_sink_out <= cfg_q[`CFG_OL_BIT] & ~drive_d;         // [R4]
        end
    end

    // sticky fault flags; a new event wins over a clear
    always @(posedge clock_in)
    begin
        if (rst_in)
        begin
            oc_fault_out <= 1'b0;
            ol_fault_out <= 1'b0;
        end
        else
        begin
            if (oc_trip)
                oc_fault_out <= 1'b1;
            else if (fault_clr_in)
                oc_fault_out <= 1'b0;
            if (ol_hit)
                ol_fault_out <= 1'b1;                                    // [R9]
            else if (fault_clr_in)
                ol_fault_out <= 1'b0;
        end
    end

    // read-back copies of the host registers
    always @(posedge clock_in)
    begin
        if (rst_in)
        begin
            cfg_rd_out   <= `CFG_RESET;
            ctl_rd_out   <= `CTL_RESET;
            lamp_bit_out <= 1'b0;
        end
        else
        begin
            cfg_rd_out   <= cfg_q;                                       // [R10]
            ctl_rd_out   <= ctl_q;
            lamp_bit_out <= lamp_q;
        end
    end
endmodule // lamp_driver_control
`default_nettype wire

// File: src/lamp_pwm_timer.v
// pwm waveform generator with internal or pin-measured frequency
`default_nettype none
`include "lamp_defs.vh"
module lamp_pwm_timer (
    // clock and reset
    input  wire         clock_in,
    input  wire         rst_in,
    // configuration
    input  wire [1:0]   sel_in,
    input  wire [6:0]   duty_in,
    // synchronised external input pin
    input  wire         ext_in,
    // waveform
    output reg          pwm_out
);
    localparam integer STEP_LO_FULL = `STEP_LO_CYC;         // prescale at 100 hz, full width
    localparam integer STEP_HI_FULL = `STEP_HI_CYC;         // prescale at 1 khz, full width
    localparam [10:0]  STEP_LO      = STEP_LO_FULL[10:0];   // prescale at 100 hz
    localparam [10:0]  STEP_HI      = STEP_HI_FULL[10:0];   // prescale at 1 khz

    reg  [10:0]         step_q;                 // prescaler count
    reg  [6:0]          phase_q;                // position in the 128-step ramp
    reg                 ext_dly_q;              // delayed pin for edge detect
    reg  [23:0]         per_cnt_q;              // cycles since last pin rise
    reg  [23:0]         per_q;                  // last measured pin period
    wire [10:0]         step_lim;               // prescale limit for the mode
    wire                ext_rise;               // rising edge of the pin
    wire [30:0]         prod;                   // period times duty
    wire [23:0]         on_cyc;                 // high time in ext-frequency mode

    assign step_lim = (sel_in == `SEL_1KHZ) ? STEP_HI : STEP_LO;
    assign ext_rise = ext_in & ~ext_dly_q;
    assign prod     = per_q * duty_in;
    assign on_cyc   = prod[30:7];

    // internal ramp: prescaler then phase
    always @(posedge clock_in)
    begin
        if (rst_in)
        begin
            step_q  <= 11'h000;
            phase_q <= 7'h00;
        end
        else if (step_q >= step_lim - 11'h001)
        begin
            step_q  <= 11'h000;
            phase_q <= phase_q + 7'h01;
        end
        else
        begin
            step_q <= step_q + 11'h001;
        end
    end

    // pin period measurement, restarted on each rising edge
    always @(posedge clock_in)
    begin
        if (rst_in)
        begin
            ext_dly_q <= 1'b0;
            per_cnt_q <= 24'h000000;
            per_q     <= 24'h000000;
        end
        else
        begin
            ext_dly_q <= ext_in;
            if (ext_rise)
            begin
                per_q     <= per_cnt_q + 24'h000001;
                per_cnt_q <= 24'h000000;
            end
            else if (per_cnt_q != 24'hffffff)
            begin
                per_cnt_q <= per_cnt_q + 24'h000001;
            end
        end
    end

    // waveform: high while the phase is below the duty value, or in ext-frequency mode while the cycles since the pin rise are below on_cyc
    always @(posedge clock_in)
    begin
        if (rst_in)
            pwm_out <= 1'b0;
        else if (sel_in == `SEL_EXTFREQ)
            pwm_out <= (ext_rise ? 24'h000000 : per_cnt_q + 24'h000001) < on_cyc;
        else
            pwm_out <= phase_q < duty_in;
    end
endmodule // lamp_pwm_timer
`default_nettype wire

// File: tb/lamp_driver_control_monitor.sv
// port-level assertion checker for the lamp driver control block
`default_nettype none
module lamp_driver_control_monitor #(
    parameter [23:0] RETRY_OFF_CYC = 24'h003e80  // retry off interval
) (
    // clock and inputs
    input wire logic       clock_in,
    input wire logic       rst_in,
    input wire logic       cfg_wr_in,
    input wire logic [7:0] cfg_data_in,
    input wire logic       fault_clr_in,
    // outputs
    input wire logic [7:0] cfg_rd_out,
    input wire logic [7:0] ctl_rd_out,
    input wire logic       oc_fault_out,
    input wire logic       ol_fault_out,
    input wire logic       lamp_drive_out,
    input wire logic       open_load_sink_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clock_in); endclocking
    default disable iff (rst_in);
    logic [23:0] off_cnt_q;  // cycles held off by a retry
    // count the off interval while a retried fault stands
    always_ff @(posedge clock_in)
    begin
        if (rst_in || lamp_drive_out || !oc_fault_out || !cfg_rd_out[7])
            off_cnt_q <= 24'h0;
        else
            off_cnt_q <= off_cnt_q + 24'h1;
    end
    property p_cfg_unused; cfg_rd_out[6:5] == 2'h0 && !cfg_rd_out[2]; endproperty
    a_cfg_unused: assert property (p_cfg_unused)
        else $error("unused config bits set");
    property p_ctl_top; ctl_rd_out[7] == 1'b0; endproperty
    a_ctl_top: assert property (p_ctl_top)
        else $error("control bit 7 set");
    property p_cfg_wr;
        cfg_wr_in ##1 !cfg_wr_in |=> cfg_rd_out == ($past(cfg_data_in, 2) & 8'h9b);
    endproperty
    a_cfg_wr: assert property (p_cfg_wr)
        else $error("config readback wrong");
    property p_sink_drive; lamp_drive_out |-> !open_load_sink_out; endproperty
    a_sink_drive: assert property (p_sink_drive)
        else $error("sink on while driving");
    property p_sink_en; !cfg_rd_out[4] |-> !open_load_sink_out; endproperty
    a_sink_en: assert property (p_sink_en)
        else $error("sink on while disabled");
    property p_oc_trip; $rose(oc_fault_out) |-> !lamp_drive_out; endproperty
    a_oc_trip: assert property (p_oc_trip)
        else $error("output on at overcurrent trip");
    property p_ol_trip; $rose(ol_fault_out) |-> $past(open_load_sink_out); endproperty
    a_ol_trip: assert property (p_ol_trip)
        else $error("open load flagged without sink");
    property p_ol_clr; fault_clr_in && !open_load_sink_out |=> !ol_fault_out; endproperty
    a_ol_clr: assert property (p_ol_clr)
        else $error("open load flag not cleared");
    property p_retry_max; off_cnt_q <= RETRY_OFF_CYC + 24'd4; endproperty
    a_retry_max: assert property (p_retry_max)
        else $error("retry off interval too long");
    property p_retry_min;
        $rose(lamp_drive_out) && off_cnt_q != 24'h0 |-> off_cnt_q >= RETRY_OFF_CYC - 24'd4;
    endproperty
    a_retry_min: assert property (p_retry_min)
        else $error("retry off interval too short");
endmodule // lamp_driver_control_monitor
bind lamp_driver_control lamp_driver_control_monitor #(.RETRY_OFF_CYC(RETRY_OFF_CYC)) u_mon (
    .clock_in(clock_in), .rst_in(rst_in), .cfg_wr_in(cfg_wr_in), .cfg_data_in(cfg_data_in),
    .fault_clr_in(fault_clr_in), .cfg_rd_out(cfg_rd_out), .ctl_rd_out(ctl_rd_out),
    .oc_fault_out(oc_fault_out), .ol_fault_out(ol_fault_out),
    .lamp_drive_out(lamp_drive_out), .open_load_sink_out(open_load_sink_out));
`default_nettype wire

// File: tb/lamp_driver_control_tb.sv
// self-checking bench for the lamp driver control block
`default_nettype none
module lamp_driver_control_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic       clock_in = 1'b0;
    logic       rst_in = 1'b1;
    logic       cfg_wr_in = 1'b0;
    logic       ctl_wr_in = 1'b0;
    logic       onoff_wr_in = 1'b0;
    logic       lamp_on_in = 1'b0;
    logic       fault_clr_in = 1'b0;
    logic       ext_pin_in = 1'b0;
    logic [7:0] cfg_data_in = 8'h00;
    logic [7:0] ctl_data_in = 8'h00;
    logic       load_short = 1'b0;  // shorted lamp
    logic       load_open = 1'b0;   // burned-out filament
    wire logic [7:0] cfg_rd_out;
    wire logic [7:0] ctl_rd_out;
    wire logic  lamp_bit_out, oc_fault_out, ol_fault_out, lamp_drive_out;
    wire logic  open_load_sink_out, oc_det, ol_det;
    int         num_errors = 0;
    int         tests_run = 0;
    int         hi, tg, n;
    always #25 clock_in = ~clock_in;
    lamp_driver_control #(.INRUSH_CYC(24'd20), .RETRY_ON_CYC(24'd5), .RETRY_OFF_CYC(24'd40),
        .OC_FILT_CYC(24'd2), .OL_FILT_CYC(24'd4)) u_dut (
        .clock_in(clock_in), .rst_in(rst_in), .cfg_wr_in(cfg_wr_in), .cfg_data_in(cfg_data_in),
        .ctl_wr_in(ctl_wr_in), .ctl_data_in(ctl_data_in), .onoff_wr_in(onoff_wr_in),
        .lamp_on_in(lamp_on_in), .fault_clr_in(fault_clr_in), .cfg_rd_out(cfg_rd_out),
        .ctl_rd_out(ctl_rd_out), .lamp_bit_out(lamp_bit_out), .oc_fault_out(oc_fault_out),
        .ol_fault_out(ol_fault_out), .ext_pin_in(ext_pin_in), .oc_det_in(oc_det),
        .ol_det_in(ol_det), .lamp_drive_out(lamp_drive_out),
        .open_load_sink_out(open_load_sink_out));
    lamp_load_model u_load (.drive_in(lamp_drive_out), .sink_in(open_load_sink_out),
        .short_in(load_short), .open_in(load_open), .oc_out(oc_det), .ol_out(ol_det));
    // compare and count
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got);
        end
    endtask
    // write pulse: 0 config, 1 lamp control, 2 on/off, 3 fault clear
    task automatic wr(input int k, input logic [7:0] d);
        @(posedge clock_in);
        #1;
        {cfg_wr_in, ctl_wr_in, onoff_wr_in, fault_clr_in} = {k == 0, k == 1, k == 2, k == 3};
        {cfg_data_in, ctl_data_in, lamp_on_in} = {d, d, d[0]};
        @(posedge clock_in);
        #1;
        {cfg_wr_in, ctl_wr_in, onoff_wr_in, fault_clr_in} = 4'h0;
    endtask
    task automatic cyc(input int c);
        repeat (c) @(posedge clock_in);
        #1;
    endtask
    // high cycles and level changes of the output over a window
    task automatic hicnt(input int c);
        logic prev;
        {hi, tg} = 0;
        prev = lamp_drive_out;
        repeat (c)
        begin
            cyc(1);
            hi += int'(lamp_drive_out === 1'b1);
            tg += int'(lamp_drive_out !== prev);
            prev = lamp_drive_out;
        end
    endtask
    task automatic report_and_stop;
        if (num_errors == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // watchdog against a hung handshake
    initial
    begin
        #2500000;
        num_errors++;
        report_and_stop;
    end
    // main sequence
    initial
    begin
        cyc(16);
        rst_in = 1'b0;
        cyc(2);
        chk("cfg_rd", 8'h18, cfg_rd_out);
        chk("ctl_rd", 8'h00, ctl_rd_out);
        chk("sink", 1, open_load_sink_out);
        chk("faults", 0, {oc_fault_out, ol_fault_out, lamp_drive_out});
        wr(0, 8'hff);
        wr(1, 8'hff);
        cyc(2);
        chk("cfg_rd", 8'h9b, cfg_rd_out);
        chk("ctl_rd", 8'h7f, ctl_rd_out);
        wr(0, 8'h00);
        wr(2, 8'h01);
        cyc(2);
        chk("sink", 0, open_load_sink_out);
        chk("drive_on", 1, lamp_drive_out);
        chk("lamp_bit", 1, lamp_bit_out);
        wr(2, 8'h00);
        ext_pin_in = 1'b1;
        cyc(5);
        chk("pin_on", 1, lamp_drive_out);
        ext_pin_in = 1'b0;
        cyc(5);
        chk("pin_off", 0, lamp_drive_out);
        wr(2, 8'h01);
        for (int s = 1; s < 4; s++)
        begin
            wr(0, 8'(s));
            wr(1, 8'h00);
            cyc(3);
            hicnt(400);
            chk("duty_zero", 0, hi);
        end
        wr(0, 8'h01);
        wr(1, 8'h40);
        cyc(3);
        hicnt(6248);
        chk("slow_pwm", 1, tg <= 1);
        wr(0, 8'h02);
        cyc(3);
        hicnt(19968);
        chk("fast_high", 9984, hi);
        chk("fast_edges", 2, tg);
        wr(0, 8'h03);
        wr(1, 8'h20);
        fork
            repeat (12)
            begin
                ext_pin_in = 1'b1;
                cyc(100);
                ext_pin_in = 1'b0;
                cyc(100);
            end
            begin
                cyc(1000);
                hicnt(800);
                chk("ext_high", 1, hi >= 196 && hi <= 204);
                chk("ext_edges", 8, tg);
            end
        join
        wr(0, 8'h08);
        cyc(3);
        load_short = 1'b1;
        for (n = 0; n < 60 && oc_fault_out !== 1'b1; n++) cyc(1);
        chk("inrush_trip", 1, n >= 20 && n <= 26);
        cyc(60);
        chk("latched", 0, lamp_drive_out);
        wr(3, 8'h00);
        wr(0, 8'h00);
        wr(2, 8'h00);
        cyc(2);
        chk("oc_clear", 0, oc_fault_out);
        chk("lamp_bit_off", 0, lamp_bit_out);
        wr(2, 8'h01);
        for (n = 0; n < 60 && oc_fault_out !== 1'b1; n++) cyc(1);
        chk("fast_trip", 1, n >= 2 && n <= 8);
        wr(0, 8'h80);
        hicnt(300);
        chk("retry_edges", 1, tg >= 8 && hi <= 60);
        load_short = 1'b0;
        cyc(100);
        chk("recovered", 1, lamp_drive_out);
        wr(3, 8'h00);
        wr(2, 8'h00);
        wr(0, 8'h10);
        cyc(3);
        load_open = 1'b1;
        for (n = 0; n < 60 && ol_fault_out !== 1'b1; n++) cyc(1);
        chk("open_trip", 1, n <= 10);
        load_open = 1'b0;
        wr(3, 8'h00);
        cyc(2);
        chk("ol_clear", 0, ol_fault_out);
        wr(0, 8'h00);
        load_open = 1'b1;
        cyc(20);
        chk("no_sink", 0, ol_fault_out);
        report_and_stop;
    end
endmodule // lamp_driver_control_tb
`default_nettype wire

// File: tb/lamp_load_model.sv
// lamp load seen through its overcurrent and low-output comparators
`default_nettype none
module lamp_load_model (
    // power stage from the block
    input wire logic  drive_in,
    input wire logic  sink_in,
    // load condition set by the bench
    input wire logic  short_in,
    input wire logic  open_in,
    // comparators back to the block
    output wire logic oc_out,
    output wire logic ol_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // a shorted load draws overcurrent whenever switched on
    assign oc_out = (drive_in === 1'b1) && short_in;
    // pin low when switched on, or pulled down with no filament
    assign ol_out = (drive_in === 1'b1) || (open_in && sink_in === 1'b1);
endmodule // lamp_load_model
`default_nettype wire
